// ==== hw/sapc_pkg.sv ====
// package: constants, register map and carrier types for the aux pin and sync control block
package sapc_pkg;

  // register index/offsets (byte addresses, one word each)
  localparam logic [7:0] SAPC_OFF_CTRL    = 8'h00;
  localparam logic [7:0] SAPC_OFF_PINCFG  = 8'h04;
  localparam logic [7:0] SAPC_OFF_STATUS  = 8'h08;
  localparam logic [7:0] SAPC_OFF_FRAMES  = 8'h0c;
  localparam logic [7:0] SAPC_OFF_BCAST   = 8'h10;

  // ctrl fields
  localparam int SAPC_CTRL_START  = 0;
  localparam int SAPC_CTRL_STOP   = 1;

  // pin config fields
  localparam int SAPC_CFG_IN2_EN  = 0;
  localparam int SAPC_CFG_IN2_FN  = 1;
  localparam int SAPC_CFG_IN3_EN  = 2;
  localparam int SAPC_CFG_IN3_FN  = 3;
  localparam int SAPC_CFG_IO0_IN  = 5;
  localparam int SAPC_CFG_IO0_FN  = 6;
  localparam int SAPC_CFG_IO1_MD  = 7;
  localparam int SAPC_CFG_IO1_FN  = 9;

  // reset values: inputs powered down, io pads as outputs
  localparam logic [9:0] SAPC_PINCFG_RST = 10'h000;
  localparam logic [1:0] SAPC_IO1_SHUTTER = 2'h0;
  localparam logic [1:0] SAPC_IO1_DAISY   = 2'h1;
  localparam logic [1:0] SAPC_IO1_INPUT   = 2'h2;

  // input function codes for a pad acting as input
  localparam logic [1:0] SAPC_FN_ADDR    = 2'h0;
  localparam logic [1:0] SAPC_FN_STANDBY = 2'h1;
  localparam logic [1:0] SAPC_FN_DAISY   = 2'h2;

  // frame timing (master clock cycles)
  localparam int SAPC_FRAME_LEN_DEF = 4000;

  typedef enum logic [2:0]
  {
    SAPC_ST_IDLE   = 3'b001,
    SAPC_ST_STREAM = 3'b010,
    SAPC_ST_DRAIN  = 3'b100
  } sapc_state_e;

  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sapc_bus_s;

  typedef struct packed
  {
    logic [1:0] in_val;
    logic [1:0] io_in;
  } sapc_pads_s;

endpackage

// ==== hw/sapc_sync2.sv ====
// two flip-flop synchroniser for a bundle of pad levels
`timescale 1ns/1ps
module sapc_sync2
#(
  parameter int W = 4
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule

// ==== hw/sapc_top.sv ====
// aux pin function mux, shutdown reset and soft-trigger streaming control
//
// Summary of operation
// - shutdown reset is async low and stops all image data output.
// - releasing shutdown reset restores every register to its default.
// - control and status registers reachable over the serial register port.
// - both aux input pads powered down after reset until configured.
// - lower aux input selects alternate bus address or standby.
// - upper aux input takes daisy input or any lower-input function.
// - lower io pad drives flash by default, else input with lower functions.
// - upper io pad drives shutter, or daisy output, or acts as input.
// - only soft trigger and global start; no hardware trigger pin function.
// - both io pads powered up after reset, defaulting to outputs.
`timescale 1ns/1ps
module sapc_top
  import sapc_pkg::*;
#(
  parameter int FRAME_LEN = SAPC_FRAME_LEN_DEF
)
(
  // clock and resets
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        shutdown_reset_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // aux input pads
  input  wire logic [1:0]  aux_inputs,
  output logic      [1:0]  aux_inputs_pwr_en,
  // aux io pads (oe low = driving)
  input  wire logic [1:0]  aux_ios_in,
  output logic      [1:0]  aux_ios_out,
  output logic      [1:0]  aux_ios_oe_n,
  output logic      [1:0]  aux_ios_pwr_en,
  // sensor side functions
  input  wire logic        flash_strobe,
  input  wire logic        shutter_sig,
  input  wire logic        daisy_out,
  output logic             daisy_in,
  output logic             alt_bus_address_select,
  output logic             standby_req,
  // image data gating
  output logic             frame_valid,
  output logic             data_out_en
);

  // ==========================================================
  // reset combine
  // ==========================================================
  // shutdown pin is async; synchronise it so registers see a clean level
  logic       sd_sync;
  logic       rst_ok;
  logic [1:0] in_s;
  logic [1:0] io_s;

  sapc_sync2 #(.W(1)) u_sd_sync
  (
    .clk  (clk),
    .nrst (nrst),
    .d    (shutdown_reset_n),
    .q    (sd_sync)
  );
  // low pin forces the combined reset at once; release waits for sync
  assign rst_ok = nrst && shutdown_reset_n && sd_sync;

  sapc_sync2 #(.W(4)) u_pad_sync
  (
    .clk  (clk),
    .nrst (rst_ok),
    .d    ({aux_inputs, aux_ios_in}),
    .q    ({in_s, io_s})
  );

  // ==========================================================
  // registers
  // ==========================================================
  logic [9:0]  pincfg_reg;
  logic        start_pend_reg;
  logic        stop_pend_reg;
  logic [15:0] frames_reg;
  logic [31:0] rdata_reg;
  sapc_state_e state_reg;
  sapc_state_e state_next;
  logic [31:0] line_cnt_reg;

  wire hit_ctrl   = reg_addr == SAPC_OFF_CTRL;
  wire hit_cfg    = reg_addr == SAPC_OFF_PINCFG;
  wire hit_stat   = reg_addr == SAPC_OFF_STATUS;
  wire hit_frames = reg_addr == SAPC_OFF_FRAMES;
  wire hit_bcast  = reg_addr == SAPC_OFF_BCAST;
  // broadcast and local writes both go through the same path and latency
  wire wr_cmd     = reg_wr && (hit_ctrl || hit_bcast);
  wire cmd_start  = wr_cmd && reg_wdata[SAPC_CTRL_START];
  wire cmd_stop   = wr_cmd && reg_wdata[SAPC_CTRL_STOP];
  wire frame_end  = line_cnt_reg == 32'(FRAME_LEN - 1);

  // ==========================================================
  // pad function decode
  // ==========================================================
  function automatic logic [2:0] fn_decode(input logic en, input logic [1:0] fn, input logic lvl);
    fn_decode = {en && fn == SAPC_FN_DAISY   && lvl,
                 en && fn == SAPC_FN_STANDBY && lvl,
                 en && fn == SAPC_FN_ADDR    && lvl};
  endfunction

  wire [1:0] in3_fn = pincfg_reg[SAPC_CFG_IN3_FN+:2];
  wire [1:0] io1_md = pincfg_reg[SAPC_CFG_IO1_MD+:2];
  wire [2:0] f_in2  = fn_decode(pincfg_reg[SAPC_CFG_IN2_EN], {1'b0, pincfg_reg[SAPC_CFG_IN2_FN]}, in_s[0]);
  wire [2:0] f_in3  = fn_decode(pincfg_reg[SAPC_CFG_IN3_EN], in3_fn, in_s[1]);
  wire [2:0] f_io0  = fn_decode(pincfg_reg[SAPC_CFG_IO0_IN], {1'b0, pincfg_reg[SAPC_CFG_IO0_FN]}, io_s[0]);
  wire [2:0] f_io1  = fn_decode(io1_md == SAPC_IO1_INPUT, {1'b0, pincfg_reg[SAPC_CFG_IO1_FN]}, io_s[1]);
  wire [2:0] f_any  = f_in2 | f_in3 | f_io0 | f_io1;

  // no trigger function exists in the decode; only soft commands start frames
  assign alt_bus_address_select = f_any[0];
  assign standby_req            = f_any[1];
  assign daisy_in               = f_any[2];

  assign aux_inputs_pwr_en = {pincfg_reg[SAPC_CFG_IN3_EN], pincfg_reg[SAPC_CFG_IN2_EN]};
  assign aux_ios_pwr_en    = 2'h3;
  assign aux_ios_oe_n      = {io1_md == SAPC_IO1_INPUT, pincfg_reg[SAPC_CFG_IO0_IN]};
  assign aux_ios_out       = {(io1_md == SAPC_IO1_DAISY) ? daisy_out : shutter_sig, flash_strobe};

  // ==========================================================
  // streaming state machine
  // ==========================================================
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SAPC_ST_IDLE:   if (start_pend_reg) state_next = SAPC_ST_STREAM;
      SAPC_ST_STREAM: if (stop_pend_reg) state_next = SAPC_ST_DRAIN;
      SAPC_ST_DRAIN:  if (frame_end) state_next = SAPC_ST_IDLE;
      default:        state_next = SAPC_ST_IDLE;
    endcase
  end

  assign frame_valid = state_reg != SAPC_ST_IDLE;
  assign data_out_en = frame_valid && rst_ok;

  // ==========================================================
  // clocked state
  // ==========================================================
  // pin config returns to defaults on every reset, shutdown included
  always_ff @(posedge clk)
  begin
    if (!rst_ok)
      pincfg_reg <= SAPC_PINCFG_RST;
    else if (reg_wr && hit_cfg)
      pincfg_reg <= reg_wdata[9:0];
  end

  // command strobes live one cycle; a stop seen in idle simply expires
  always_ff @(posedge clk)
  begin
    if (!rst_ok)
    begin
      start_pend_reg <= 1'b0;
      stop_pend_reg  <= 1'b0;
    end
    else
    begin
      start_pend_reg <= cmd_start;
      stop_pend_reg  <= cmd_stop;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_ok)
      state_reg <= SAPC_ST_IDLE;
    else
      state_reg <= state_next;
  end

  // counter runs only while frames go out; clears at each frame boundary
  wire        cnt_clr       = (state_reg == SAPC_ST_IDLE) || frame_end;
  wire [31:0] line_cnt_next = cnt_clr ? 32'h0000_0000 : line_cnt_reg + 32'h0000_0001;

  always_ff @(posedge clk)
  begin
    if (!rst_ok)
      line_cnt_reg <= 32'h0000_0000;
    else
      line_cnt_reg <= line_cnt_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_ok)
      frames_reg <= 16'h0000;
    else if (state_reg != SAPC_ST_IDLE && frame_end)
      frames_reg <= frames_reg + 16'h0001;
  end

  // ==========================================================
  // register read port
  // ==========================================================
  wire [31:0] rd_mux = hit_cfg    ? {22'h0, pincfg_reg} :
                       hit_stat   ? {29'h0, state_reg} :
                       hit_frames ? {16'h0, frames_reg} :
                       32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (!rst_ok)
      rdata_reg <= 32'h0000_0000;
    else if (reg_rd)
      rdata_reg <= rd_mux;
    else
      rdata_reg <= 32'h0000_0000;
  end

  assign reg_rdata = rdata_reg;

endmodule

// ==== tb/sapc_monitor.sv ====
// checker for pad defaults, read port and streaming
`timescale 1ns/1ps
module sapc_monitor
  import sapc_pkg::*;
#(
  parameter int FRAME_LEN = 8
)
(
  // clock and resets
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        shutdown_reset_n,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // pads
  input wire logic [1:0]  aux_inputs_pwr_en,
  input wire logic [1:0]  aux_ios_out,
  input wire logic [1:0]  aux_ios_oe_n,
  input wire logic [1:0]  aux_ios_pwr_en,
  input wire logic        flash_strobe,
  // streaming
  input wire logic        frame_valid,
  input wire logic        data_out_en
);
  // =====================================
  // properties
  localparam int DMAX = FRAME_LEN + 2;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire ctl = reg_wr && (reg_addr == SAPC_OFF_CTRL || reg_addr == SAPC_OFF_BCAST);
  sequence start_wr;
    ctl && reg_wdata[0] && shutdown_reset_n && !frame_valid;
  endsequence
  sequence stop_wr;
    ctl && reg_wdata[1] && frame_valid;
  endsequence
  AST_START: assert property (start_wr |=> !frame_valid ##1 frame_valid)
    else $error("late start");
  // drain bound assumes a short frame
  AST_DRAIN: assert property (stop_wr |=> frame_valid ##[1:DMAX] !frame_valid)
    else $error("bad drain");
  AST_CAUSE: assert property ($rose(frame_valid) |-> $past(ctl, 2))
    else $error("stream without command");
  AST_SHUT: assert property (!shutdown_reset_n |-> !data_out_en)
    else $error("data during shutdown");
  AST_GATE: assert property (shutdown_reset_n |-> data_out_en == frame_valid)
    else $error("gate mismatch");
  AST_RDZ: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("stray read data");
  AST_FLASH: assert property (!aux_ios_oe_n[0] |-> aux_ios_out[0] == flash_strobe)
    else $error("flash not on pad");
  AST_PWR: assert property (aux_ios_pwr_en == 2'h3)
    else $error("io pad powered down");
  AST_RST: assert property ($rose(nrst) |-> aux_ios_oe_n == 2'h0 && aux_inputs_pwr_en == 2'h0)
    else $error("bad pad reset");
endmodule
bind sapc_top sapc_monitor #(.FRAME_LEN(FRAME_LEN)) i_sapc_monitor (.clk, .nrst, .shutdown_reset_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .aux_inputs_pwr_en, .aux_ios_out,
  .aux_ios_oe_n, .aux_ios_pwr_en, .flash_strobe, .frame_valid, .data_out_en);

// ==== tb/sapc_host_model.sv ====
// host model: register master on the shared control bus
`timescale 1ns/1ps
module sapc_host_model
(
  // clock
  input wire logic        clk,
  // register port
  output logic     [7:0]  reg_addr,
  output logic     [31:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input wire logic [31:0] reg_rdata
);
  // =====================================
  // bus cycles
  initial
  begin
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  // stop timed by caller to fix the frame count
  task automatic stream(input logic [7:0] a, input int cyc);
    wr(a, 32'h1);
    repeat (cyc) @(posedge clk);
    wr(a, 32'h2);
  endtask
endmodule

// ==== tb/sapc_top_bench.sv ====
// testbench: pad functions, register port, streaming, shutdown
`timescale 1ns/1ps
module sapc_top_bench;
  import sapc_pkg::*;
  localparam int FL = 8;
  logic clk, nrst, shutdown_reset_n, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [1:0] aux_inputs, aux_inputs_pwr_en, aux_ios_in, aux_ios_out, aux_ios_oe_n, aux_ios_pwr_en;
  logic flash_strobe, shutter_sig, daisy_out, daisy_in, alt_bus_address_select, standby_req;
  logic frame_valid, data_out_en;
  wire [6:0] pins = {aux_inputs_pwr_en, aux_ios_oe_n, daisy_in, alt_bus_address_select, standby_req};
  int err_count = 0;
  int n_compared = 0;
  logic [9:0] cfg[10] = '{10'h001, 10'h003, 10'h014, 10'h00c, 10'h060, 10'h100, 10'h004, 10'h300, 10'h020, 10'h080};
  logic [3:0] pad[10] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h8, 4'h2, 4'h8, 4'h4, 4'h8};
  logic [6:0] want[10] = '{7'h22, 7'h21, 7'h44, 7'h41, 7'h09, 7'h12, 7'h42, 7'h11, 7'h0a, 7'h00};
  sapc_top #(.FRAME_LEN(FL)) i_sapc_top (.clk, .nrst, .shutdown_reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .aux_inputs, .aux_inputs_pwr_en, .aux_ios_in, .aux_ios_out,
    .aux_ios_oe_n, .aux_ios_pwr_en, .flash_strobe, .shutter_sig, .daisy_out, .daisy_in,
    .alt_bus_address_select, .standby_req, .frame_valid, .data_out_en);
  sapc_host_model i_sapc_host_model (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  // =====================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    i_sapc_host_model.rd(a, v);
    chk("rdata", v, e);
  endtask
  task automatic fv_end;
    for (int k = 0; k < 40 && frame_valid; k++) @(posedge clk);
  endtask
  task automatic results;
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // run needs under two hundred cycles
  initial
  begin
    #20000;
    err_count++;
    results();
  end
  // =====================================
  // tests
  initial
  begin
    nrst = 1'b0;
    shutdown_reset_n = 1'b1;
    {aux_inputs, aux_ios_in} = 4'h0;
    {flash_strobe, shutter_sig, daisy_out} = 3'h0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pads", 32'({aux_inputs_pwr_en, aux_ios_oe_n, aux_ios_pwr_en}), 32'h3);
    rchk(SAPC_OFF_PINCFG, 32'h0);
    rchk(8'h14, 32'h0);
    i_sapc_host_model.wr(SAPC_OFF_STATUS, 32'h4);
    rchk(SAPC_OFF_STATUS, 32'h1);
    {flash_strobe, shutter_sig} <= 2'h3;
    @(posedge clk);
    #1 chk("ios_out", 32'(aux_ios_out), 32'h3);
    {flash_strobe, shutter_sig, daisy_out} <= 3'h1;
    for (int i = 0; i < 10; i++)
    begin
      i_sapc_host_model.wr(SAPC_OFF_PINCFG, 32'(cfg[i]));
      {aux_ios_in, aux_inputs} <= pad[i];
      repeat (4) @(posedge clk);
      chk("pin", 32'(pins), 32'(want[i]));
    end
    chk("daisy_out", 32'(aux_ios_out[1]), 32'h1);
    i_sapc_host_model.wr(SAPC_OFF_CTRL, 32'h2);
    rchk(SAPC_OFF_STATUS, 32'h1);
    i_sapc_host_model.stream(SAPC_OFF_CTRL, 2 * FL - 3);
    chk("drain", 32'(frame_valid), 32'h1);
    rchk(SAPC_OFF_STATUS, 32'h4);
    fv_end();
    rchk(SAPC_OFF_FRAMES, 32'h2);
    i_sapc_host_model.stream(SAPC_OFF_BCAST, 2 * FL - 3);
    fv_end();
    rchk(SAPC_OFF_FRAMES, 32'h4);
    i_sapc_host_model.wr(SAPC_OFF_BCAST, 32'h1);
    repeat (5) @(posedge clk);
    chk("data_en", 32'(data_out_en), 32'h1);
    shutdown_reset_n <= 1'b0;
    #1 chk("data_en", 32'(data_out_en), 32'h0);
    repeat (3) @(posedge clk);
    shutdown_reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    rchk(SAPC_OFF_PINCFG, 32'h0);
    rchk(SAPC_OFF_STATUS, 32'h1);
    rchk(SAPC_OFF_FRAMES, 32'h0);
    results();
  end
endmodule
